// File: include/pin_steer_regs.vh
// How it works
// - Selection bits never touch direction bits; overrides follow the selected pin only.
// - Select-one bit 7 puts comparator 2 output on pin_a6, else pin_a5.
// - Bit 6 puts capture/compare channel 1 on pin_b0, else pin_c2.
// - Bit 5 puts serial data out on pin_b5, else pin_c5.
// - Bit 4 puts serial clock on pin_b7, else pin_c3.
// - Bit 3 puts serial data in/SDA on pin_b6, else pin_c4.
// - Bit 2 puts UART transmit on pin_b6, else pin_c6.
// - Bit 1 puts UART receive on pin_b7, else pin_c7.
// - Bit 0 puts capture/compare channel 2 on pin_b3, else pin_c1.
// - Select-two has only bit 0; channel 3 on pin_b5, else pin_c6 or pin_e0.
// - Every port has direction, pin level and latch; analog and pull-up where present.
// - Writing the pin level register writes the output latch.
// - Latch reads return stored values; pin level reads return pin levels.
// - A set analog select bit disables that pin's digital input.
// - A peripheral owning a pin blocks the latch but the pin stays readable.
// - Without port D only ports A, B, C and E exist.
// - Direction one makes an input; zero drives the latch value.
// - Analog pins read zero in the pin level register.
// - Several enabled outputs on one pin: highest priority function drives it.
`ifndef PIN_STEER_REGS_VH
`define PIN_STEER_REGS_VH
// ==========================================
// Register offsets
`define SEL_ONE_OFS 12'h000
`define SEL_TWO_OFS 12'h004
`define FLD_DIR 3'h0
`define FLD_LEVEL 3'h1
`define FLD_LAT 3'h2
`define FLD_ANSEL 3'h3
`define FLD_WPU 3'h4
// ==========================================
// Selection bit positions
`define C2_SEL_BIT 7
`define CC1_SEL_BIT 6
`define SDO_SEL_BIT 5
`define SCK_SEL_BIT 4
`define SDI_SEL_BIT 3
`define TX_SEL_BIT 2
`define RX_SEL_BIT 1
`define CC2_SEL_BIT 0
`define CC3_SEL_BIT 0
// ==========================================
// Reset values
`define SEL_ONE_RST 8'h00
`define SEL_TWO_RST 1'h0
`define DIR_RST 8'hFF
`define LAT_RST 8'h00
`define ANSEL_RST 8'hFF
`define WPU_RST 8'h00
`endif

// File: rtl/level_sync.v
`timescale 1ns/1ps
module level_sync #(
  parameter WIDTH = 40
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  // ==========================================
  // Two flops; the first is read by the second only
  reg [WIDTH-1:0] meta_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // level_sync

// File: rtl/port_bank.v
`timescale 1ns/1ps
`include "pin_steer_regs.vh"
module port_bank #(
  parameter PRESENT = 1,
  parameter [7:0] ANSEL_MASK = 8'hFF,
  parameter [7:0] WPU_MASK = 8'hFF
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Register writes
  input wire wr_dir,
  input wire wr_lat,
  input wire wr_ansel,
  input wire wr_wpu,
  input wire [7:0] wdata,
  // Pin side
  input wire [7:0] pin_sync,
  input wire [7:0] ovr_en,
  input wire [7:0] ovr_val,
  // Register state
  output reg [7:0] dir_r,
  output reg [7:0] lat_r,
  output reg [7:0] ansel_r,
  output reg [7:0] wpu_r,
  // Pin drive
  output wire [7:0] level,
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe,
  output wire [7:0] pullup_en
);
  localparam [7:0] PMASK = PRESENT ? 8'hFF : 8'h00;

  // ==========================================
  // Port registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= `DIR_RST & PMASK;
      lat_r <= `LAT_RST;
      ansel_r <= `ANSEL_RST & ANSEL_MASK & PMASK;
      wpu_r <= `WPU_RST;
    end else if (ce) begin
      if (wr_dir)
        dir_r <= wdata & PMASK;
      if (wr_lat)
        lat_r <= wdata & PMASK;
      if (wr_ansel)
        ansel_r <= wdata & ANSEL_MASK & PMASK;
      if (wr_wpu)
        wpu_r <= wdata & WPU_MASK & PMASK;
    end
  end

  // ==========================================
  // Pin composition
  // Input buffer off under analog select, so reads give zero
  assign level = pin_sync & ~ansel_r & PMASK;
  // Peripheral wins over the latch; direction bit left alone
  assign pin_out = (ovr_en & ovr_val) | (~ovr_en & lat_r);
  assign pin_oe = (ovr_en | ~dir_r) & PMASK;
  // Pull-up only helps an undriven input
  assign pullup_en = wpu_r & dir_r & ~ovr_en;
endmodule // port_bank

// File: rtl/pin_steer.v
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pin_steer_regs.vh"
module pin_steer #(
  parameter HAS_PORT_D = 1,
  parameter [7:0] ANSEL_MASK_A = 8'hFF,
  parameter [7:0] ANSEL_MASK_B = 8'hFF,
  parameter [7:0] ANSEL_MASK_C = 8'hFF,
  parameter [7:0] ANSEL_MASK_D = 8'hFF,
  parameter [7:0] ANSEL_MASK_E = 8'h07,
  parameter [7:0] WPU_MASK_A = 8'hFF,
  parameter [7:0] WPU_MASK_B = 8'hFF,
  parameter [7:0] WPU_MASK_C = 8'hFF,
  parameter [7:0] WPU_MASK_D = 8'hFF,
  parameter [7:0] WPU_MASK_E = 8'h0F
) (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Port pins
  input wire [7:0] pin_in_a,
  input wire [7:0] pin_in_b,
  input wire [7:0] pin_in_c,
  input wire [7:0] pin_in_d,
  input wire [7:0] pin_in_e,
  output wire [7:0] pin_out_a,
  output wire [7:0] pin_out_b,
  output wire [7:0] pin_out_c,
  output wire [7:0] pin_out_d,
  output wire [7:0] pin_out_e,
  output wire [7:0] pin_oe_a,
  output wire [7:0] pin_oe_b,
  output wire [7:0] pin_oe_c,
  output wire [7:0] pin_oe_d,
  output wire [7:0] pin_oe_e,
  output wire [7:0] pullup_en_a,
  output wire [7:0] pullup_en_b,
  output wire [7:0] pullup_en_c,
  output wire [7:0] pullup_en_d,
  output wire [7:0] pullup_en_e,
  // Comparator 2
  input wire comparator2_output,
  input wire comparator2_out_en,
  // Capture/compare channels
  input wire capcomp1_out,
  input wire capcomp1_out_en,
  output wire capcomp1_in,
  input wire capcomp2_out,
  input wire capcomp2_out_en,
  output wire capcomp2_in,
  input wire capcomp3_out,
  input wire capcomp3_out_en,
  output wire capcomp3_in,
  // Serial port
  input wire serial_dout,
  input wire serial_dout_en,
  input wire serial_clock_out,
  input wire serial_clock_out_en,
  output wire serial_clock_in,
  input wire serial_din_out,
  input wire serial_din_out_en,
  output wire serial_din_in,
  // UART
  input wire uart_transmit_out,
  input wire uart_transmit_out_en,
  input wire uart_receive_out,
  input wire uart_receive_out_en,
  output wire uart_receive_in,
  // Selection state
  output wire [7:0] pin_steer_select_one,
  output wire pin_steer_select_two
);
  // ==========================================
  // Pin positions in the flat 40-bit vectors
  localparam [5:0] PA5 = 6'h05;
  localparam [5:0] PA6 = 6'h06;
  localparam [5:0] PB0 = 6'h08;
  localparam [5:0] PB3 = 6'h0B;
  localparam [5:0] PB5 = 6'h0D;
  localparam [5:0] PB6 = 6'h0E;
  localparam [5:0] PB7 = 6'h0F;
  localparam [5:0] PC1 = 6'h11;
  localparam [5:0] PC2 = 6'h12;
  localparam [5:0] PC3 = 6'h13;
  localparam [5:0] PC4 = 6'h14;
  localparam [5:0] PC5 = 6'h15;
  localparam [5:0] PC6 = 6'h16;
  localparam [5:0] PC7 = 6'h17;
  localparam [5:0] PE0 = 6'h20;
  localparam [5:0] CC3_CLEAR_PIN = HAS_PORT_D ? PE0 : PC6;

  // ==========================================
  // Address decode
  function port_hit;
    input [11:0] a;
    begin
      port_hit = (a[11:8] == 4'h0) && (a[1:0] == 2'h0) && (a[7:5] >= 3'h1)
        && (a[7:5] <= 3'h5) && (a[4:2] <= `FLD_WPU)
        && ((a[7:5] != 3'h4) || (HAS_PORT_D != 0));
    end
  endfunction

  function [2:0] port_of;
    input [11:0] a;
    begin
      port_of = a[7:5] - 3'h1;
    end
  endfunction

  // ==========================================
  // Selection registers and bus strobes
  reg [7:0] sel_one_r;
  reg sel_two_r;
  wire setup_ph = psel & ~penable & ce;
  wire wr_go = psel & penable & pwrite & ce;
  wire bank_wr = wr_go & port_hit(paddr);
  wire [2:0] wr_port = port_of(paddr);
  wire [2:0] wr_fld = paddr[4:2];

  // Zero wait states; a frozen block stretches the access
  assign pready = ce;
  assign pin_steer_select_one = sel_one_r;
  assign pin_steer_select_two = sel_two_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_one_r <= `SEL_ONE_RST;
      sel_two_r <= `SEL_TWO_RST;
    end else if (wr_go) begin
      if (paddr == `SEL_ONE_OFS)
        sel_one_r <= pwdata[7:0];
      if (paddr == `SEL_TWO_OFS)
        sel_two_r <= pwdata[`CC3_SEL_BIT];
    end
  end

  // ==========================================
  // Pin input synchronisers
  wire [39:0] pin_in_all = {pin_in_e, pin_in_d, pin_in_c, pin_in_b, pin_in_a};
  wire [39:0] pin_sync_all;

  level_sync #(
    .WIDTH(40)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(pin_in_all),
    .sync_out(pin_sync_all)
  );

  // ==========================================
  // Port banks
  wire [39:0] dir_all;
  wire [39:0] lat_all;
  wire [39:0] ansel_all;
  wire [39:0] wpu_all;
  wire [39:0] level_all;
  wire [39:0] out_all;
  wire [39:0] oe_all;
  wire [39:0] pull_all;
  reg [39:0] ovr_en;
  reg [39:0] ovr_val;
  localparam [39:0] ANSEL_MASKS = {ANSEL_MASK_E, ANSEL_MASK_D, ANSEL_MASK_C,
    ANSEL_MASK_B, ANSEL_MASK_A};
  localparam [39:0] WPU_MASKS = {WPU_MASK_E, WPU_MASK_D, WPU_MASK_C, WPU_MASK_B,
    WPU_MASK_A};

  genvar p;
  generate
    for (p = 0; p < 5; p = p + 1) begin : g_port
      wire this_port = bank_wr && (wr_port == p);
      port_bank #(
        .PRESENT((p != 3) || (HAS_PORT_D != 0)),
        .ANSEL_MASK(ANSEL_MASKS[p*8 +: 8]),
        .WPU_MASK(WPU_MASKS[p*8 +: 8])
      ) u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_dir(this_port && (wr_fld == `FLD_DIR)),
        .wr_lat(this_port && ((wr_fld == `FLD_LAT) || (wr_fld == `FLD_LEVEL))),
        .wr_ansel(this_port && (wr_fld == `FLD_ANSEL)),
        .wr_wpu(this_port && (wr_fld == `FLD_WPU)),
        .wdata(pwdata[7:0]),
        .pin_sync(pin_sync_all[p*8 +: 8]),
        .ovr_en(ovr_en[p*8 +: 8]),
        .ovr_val(ovr_val[p*8 +: 8]),
        .dir_r(dir_all[p*8 +: 8]),
        .lat_r(lat_all[p*8 +: 8]),
        .ansel_r(ansel_all[p*8 +: 8]),
        .wpu_r(wpu_all[p*8 +: 8]),
        .level(level_all[p*8 +: 8]),
        .pin_out(out_all[p*8 +: 8]),
        .pin_oe(oe_all[p*8 +: 8]),
        .pullup_en(pull_all[p*8 +: 8])
      );
    end
  endgenerate

  assign pin_out_a = out_all[7:0];
  assign pin_out_b = out_all[15:8];
  assign pin_out_c = out_all[23:16];
  assign pin_out_d = out_all[31:24];
  assign pin_out_e = out_all[39:32];
  assign pin_oe_a = oe_all[7:0];
  assign pin_oe_b = oe_all[15:8];
  assign pin_oe_c = oe_all[23:16];
  assign pin_oe_d = oe_all[31:24];
  assign pin_oe_e = oe_all[39:32];
  assign pullup_en_a = pull_all[7:0];
  assign pullup_en_b = pull_all[15:8];
  assign pullup_en_c = pull_all[23:16];
  assign pullup_en_d = pull_all[31:24];
  assign pullup_en_e = pull_all[39:32];

  // ==========================================
  // Output steering
  // Lowest priority first; later assignments win on shared pins:
  // serial port over UART over capture/compare
  reg [5:0] cc3_pin;
  always @* begin
    ovr_en = 40'h00_0000_0000;
    ovr_val = 40'h00_0000_0000;
    cc3_pin = sel_two_r ? PB5 : CC3_CLEAR_PIN;
    if (capcomp3_out_en) begin
      ovr_en[cc3_pin] = 1'b1;
      ovr_val[cc3_pin] = capcomp3_out;
    end
    if (capcomp2_out_en) begin
      ovr_en[sel_one_r[`CC2_SEL_BIT] ? PB3 : PC1] = 1'b1;
      ovr_val[sel_one_r[`CC2_SEL_BIT] ? PB3 : PC1] = capcomp2_out;
    end
    if (capcomp1_out_en) begin
      ovr_en[sel_one_r[`CC1_SEL_BIT] ? PB0 : PC2] = 1'b1;
      ovr_val[sel_one_r[`CC1_SEL_BIT] ? PB0 : PC2] = capcomp1_out;
    end
    if (comparator2_out_en) begin
      ovr_en[sel_one_r[`C2_SEL_BIT] ? PA6 : PA5] = 1'b1;
      ovr_val[sel_one_r[`C2_SEL_BIT] ? PA6 : PA5] = comparator2_output;
    end
    if (uart_receive_out_en) begin
      ovr_en[sel_one_r[`RX_SEL_BIT] ? PB7 : PC7] = 1'b1;
      ovr_val[sel_one_r[`RX_SEL_BIT] ? PB7 : PC7] = uart_receive_out;
    end
    if (uart_transmit_out_en) begin
      ovr_en[sel_one_r[`TX_SEL_BIT] ? PB6 : PC6] = 1'b1;
      ovr_val[sel_one_r[`TX_SEL_BIT] ? PB6 : PC6] = uart_transmit_out;
    end
    if (serial_din_out_en) begin
      ovr_en[sel_one_r[`SDI_SEL_BIT] ? PB6 : PC4] = 1'b1;
      ovr_val[sel_one_r[`SDI_SEL_BIT] ? PB6 : PC4] = serial_din_out;
    end
    if (serial_clock_out_en) begin
      ovr_en[sel_one_r[`SCK_SEL_BIT] ? PB7 : PC3] = 1'b1;
      ovr_val[sel_one_r[`SCK_SEL_BIT] ? PB7 : PC3] = serial_clock_out;
    end
    if (serial_dout_en) begin
      ovr_en[sel_one_r[`SDO_SEL_BIT] ? PB5 : PC5] = 1'b1;
      ovr_val[sel_one_r[`SDO_SEL_BIT] ? PB5 : PC5] = serial_dout;
    end
  end

  // ==========================================
  // Input steering
  // Only the selected pin feeds a peripheral; analog pins give zero
  assign capcomp1_in = level_all[sel_one_r[`CC1_SEL_BIT] ? PB0 : PC2];
  assign capcomp2_in = level_all[sel_one_r[`CC2_SEL_BIT] ? PB3 : PC1];
  assign capcomp3_in = level_all[sel_two_r ? PB5 : CC3_CLEAR_PIN];
  assign serial_clock_in = level_all[sel_one_r[`SCK_SEL_BIT] ? PB7 : PC3];
  assign serial_din_in = level_all[sel_one_r[`SDI_SEL_BIT] ? PB6 : PC4];
  assign uart_receive_in = level_all[sel_one_r[`RX_SEL_BIT] ? PB7 : PC7];

  // ==========================================
  // Read path
  // Captured in the setup phase so read data leaves a flop
  reg [7:0] rd_nxt;
  reg err_nxt;
  reg [2:0] rd_port;
  always @* begin
    rd_nxt = 8'h00;
    err_nxt = 1'b0;
    rd_port = port_of(paddr);
    if (paddr == `SEL_ONE_OFS) begin
      rd_nxt = sel_one_r;
    end else if (paddr == `SEL_TWO_OFS) begin
      rd_nxt = {7'h00, sel_two_r};
    end else if (port_hit(paddr)) begin
      case (paddr[4:2])
        `FLD_DIR: rd_nxt = dir_all[rd_port*8 +: 8];
        `FLD_LEVEL: rd_nxt = level_all[rd_port*8 +: 8];
        `FLD_LAT: rd_nxt = lat_all[rd_port*8 +: 8];
        `FLD_ANSEL: rd_nxt = ansel_all[rd_port*8 +: 8];
        `FLD_WPU: rd_nxt = wpu_all[rd_port*8 +: 8];
        default: rd_nxt = 8'h00;
      endcase
    end else begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_nxt};
      pslverr <= err_nxt;
    end
  end
endmodule // pin_steer

// File: tb/pin_steer_chk.sv
`timescale 1ns/1ps
module pin_steer_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Selection state
  input wire [7:0] pin_steer_select_one,
  input wire pin_steer_select_two,
  // Peripheral outputs
  input wire comparator2_output,
  input wire comparator2_out_en,
  input wire capcomp1_out,
  input wire capcomp1_out_en,
  input wire capcomp2_out,
  input wire capcomp2_out_en,
  input wire capcomp3_out,
  input wire capcomp3_out_en,
  input wire serial_dout,
  input wire serial_dout_en,
  input wire serial_clock_out,
  input wire serial_clock_out_en,
  input wire serial_din_out,
  input wire serial_din_out_en,
  input wire uart_transmit_out,
  input wire uart_transmit_out_en,
  input wire uart_receive_out,
  input wire uart_receive_out_en,
  // Pins
  input wire [7:0] pin_out_a,
  input wire [7:0] pin_out_b,
  input wire [7:0] pin_out_c,
  input wire [7:0] pin_out_e,
  input wire [7:0] pin_oe_a,
  input wire [7:0] pin_oe_b,
  input wire [7:0] pin_oe_c,
  input wire [7:0] pin_oe_e
);
  wire [7:0] s1 = pin_steer_select_one;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Routing
  property routed(en, s, v, ob, pb, oc, pc);
    en |-> (s ? (ob && pb == v) : (oc && pc == v));
  endproperty
  c2_route_a: assert property (routed(comparator2_out_en, s1[7], comparator2_output,
    pin_oe_a[6], pin_out_a[6], pin_oe_a[5], pin_out_a[5])) else $error("c2 route");
  cc1_route_a: assert property (routed(capcomp1_out_en, s1[6], capcomp1_out,
    pin_oe_b[0], pin_out_b[0], pin_oe_c[2], pin_out_c[2])) else $error("cc1 route");
  sdo_route_a: assert property (routed(serial_dout_en, s1[5], serial_dout,
    pin_oe_b[5], pin_out_b[5], pin_oe_c[5], pin_out_c[5])) else $error("sdo route");
  sck_route_a: assert property (routed(serial_clock_out_en, s1[4], serial_clock_out,
    pin_oe_b[7], pin_out_b[7], pin_oe_c[3], pin_out_c[3])) else $error("sck route");
  sdi_route_a: assert property (routed(serial_din_out_en, s1[3], serial_din_out,
    pin_oe_b[6], pin_out_b[6], pin_oe_c[4], pin_out_c[4])) else $error("sdi route");
  // Excused only when a higher function really shares the selected pin
  tx_route_a: assert property (routed(uart_transmit_out_en
    && !(serial_din_out_en && s1[3] && s1[2]),
    s1[2], uart_transmit_out, pin_oe_b[6], pin_out_b[6], pin_oe_c[6], pin_out_c[6]))
    else $error("tx route");
  rx_route_a: assert property (routed(uart_receive_out_en
    && !(serial_clock_out_en && s1[4] && s1[1]),
    s1[1], uart_receive_out, pin_oe_b[7], pin_out_b[7], pin_oe_c[7], pin_out_c[7]))
    else $error("rx route");
  cc2_route_a: assert property (routed(capcomp2_out_en, s1[0], capcomp2_out,
    pin_oe_b[3], pin_out_b[3], pin_oe_c[1], pin_out_c[1])) else $error("cc2 route");
  cc3_route_a: assert property (routed(capcomp3_out_en
    && !(serial_dout_en && s1[5] && pin_steer_select_two),
    pin_steer_select_two, capcomp3_out, pin_oe_b[5], pin_out_b[5], pin_oe_e[0], pin_out_e[0]))
    else $error("cc3 route");
  // Serial port outranks the UART on a shared pin
  shared_prio_a: assert property (serial_din_out_en && uart_transmit_out_en && s1[3]
    && s1[2] |-> pin_out_b[6] == serial_din_out) else $error("shared pin priority");
  sel_reset_a: assert property ($rose(presetn) |-> s1 == 8'h00 && !pin_steer_select_two)
    else $error("select reset");
  cover property (s1 == 8'hFF && uart_transmit_out_en);
  cover property (s1 == 8'h00 && comparator2_out_en);
  cover property (pin_steer_select_two && capcomp3_out_en);
endmodule // pin_steer_chk
bind pin_steer pin_steer_chk i_pin_steer_chk (.*);

// File: tb/pin_pad_model.sv
`timescale 1ns/1ps
module pin_pad_model (
  // Block side
  input wire [39:0] drv_val,
  input wire [39:0] drv_en,
  input wire [39:0] pull_en,
  // Board side
  input wire [39:0] ext_val,
  output wire [39:0] pin_lvl
);
  // ==========================================
  // Pad level
  // Idle pad: pull-up wins, else the board's own level
  assign pin_lvl = (drv_en & drv_val) | (~drv_en & (pull_en | ext_val));
endmodule // pin_pad_model

// File: tb/alternate_pin_function_steering_tb_top.sv
`timescale 1ns/1ps
module alternate_pin_function_steering_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [8:0] pe = 9'h000;
  reg [8:0] po = 9'h000;
  reg [39:0] ext = 40'h0;
  reg [7:0] sel_tab [0:3];
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire rx_in;
  wire [4:0] fin;
  wire [7:0] sel1_o;
  wire sel2_o;
  wire [39:0] pout;
  wire [39:0] poe;
  wire [39:0] ppu;
  wire [39:0] pin;
  integer err_total = 0;
  integer n_tests = 0;
  integer i;
  always #25 pclk = ~pclk;
  pin_pad_model i_pin_pad_model (.drv_val(pout), .drv_en(poe), .pull_en(ppu),
    .ext_val(ext), .pin_lvl(pin));
  pin_steer i_pin_steer (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .pin_in_a(pin[7:0]), .pin_in_b(pin[15:8]), .pin_in_c(pin[23:16]),
    .pin_in_d(pin[31:24]), .pin_in_e(pin[39:32]),
    .pin_out_a(pout[7:0]), .pin_out_b(pout[15:8]), .pin_out_c(pout[23:16]),
    .pin_out_d(pout[31:24]), .pin_out_e(pout[39:32]),
    .pin_oe_a(poe[7:0]), .pin_oe_b(poe[15:8]), .pin_oe_c(poe[23:16]),
    .pin_oe_d(poe[31:24]), .pin_oe_e(poe[39:32]),
    .pullup_en_a(ppu[7:0]), .pullup_en_b(ppu[15:8]), .pullup_en_c(ppu[23:16]),
    .pullup_en_d(ppu[31:24]), .pullup_en_e(ppu[39:32]),
    .comparator2_output(po[0]), .comparator2_out_en(pe[0]),
    .capcomp1_out(po[1]), .capcomp1_out_en(pe[1]), .capcomp1_in(fin[0]),
    .capcomp2_out(po[2]), .capcomp2_out_en(pe[2]), .capcomp2_in(fin[1]),
    .capcomp3_out(po[3]), .capcomp3_out_en(pe[3]), .capcomp3_in(fin[2]),
    .serial_dout(po[4]), .serial_dout_en(pe[4]),
    .serial_clock_out(po[5]), .serial_clock_out_en(pe[5]), .serial_clock_in(fin[3]),
    .serial_din_out(po[6]), .serial_din_out_en(pe[6]), .serial_din_in(fin[4]),
    .uart_transmit_out(po[7]), .uart_transmit_out_en(pe[7]),
    .uart_receive_out(po[8]), .uart_receive_out_en(pe[8]), .uart_receive_in(rx_in),
    .pin_steer_select_one(sel1_o), .pin_steer_select_two(sel2_o));
  // ==========================================
  // Checking and bus tasks
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  // e[8] is the expected error flag, e[7:0] the expected read byte
  task acc(input [11:0] a, input w, input [7:0] d, input [8:0] e);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      if (!w) chk(prdata, {24'h0, e[7:0]});
      chk({31'h0, pslverr}, {31'h0, e[8]});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task report_and_stop;
    begin
      if (err_total == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ==========================================
  // Watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    err_total = err_total + 1;
    report_and_stop;
  end
  // ==========================================
  // Tests
  initial begin
    sel_tab[0] = 8'h00;
    sel_tab[1] = 8'hFF;
    sel_tab[2] = 8'h55;
    sel_tab[3] = 8'hAA;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc(12'h000, 1'b0, 8'h00, 9'h000);
    acc(12'h004, 1'b0, 8'h00, 9'h000);
    acc(12'h020, 1'b0, 8'h00, 9'h0FF);
    acc(12'h080, 1'b0, 8'h00, 9'h0FF);
    acc(12'h0F0, 1'b0, 8'h00, 9'h100);
    acc(12'h0F0, 1'b1, 8'hFF, 9'h100);
    acc(12'h004, 1'b1, 8'hFF, 9'h000);
    acc(12'h004, 1'b0, 8'h00, 9'h001);
    // Four select-one patterns, each with select-two clear then set, all peripherals driving
    for (i = 0; i < 8; i = i + 1) begin
      acc(12'h000, 1'b1, sel_tab[i % 4], 9'h000);
      acc(12'h004, 1'b1, {7'h0, i[2]}, 9'h000);
      po <= i[0] ? 9'h155 : 9'h0AA;
      pe <= 9'h1FF;
      @(posedge pclk);
    end
    pe <= 9'h000;
    acc(12'h020, 1'b0, 8'h00, 9'h0FF);
    acc(12'h000, 1'b1, 8'h00, 9'h000);
    acc(12'h020, 1'b1, 8'h00, 9'h000);
    acc(12'h024, 1'b1, 8'h5A, 9'h000);
    acc(12'h028, 1'b0, 8'h00, 9'h05A);
    chk({24'h0, pout[7:0]}, 32'h5A);
    chk({24'h0, poe[7:0]}, 32'hFF);
    pe <= 9'h001;
    po <= 9'h001;
    @(posedge pclk);
    chk({24'h0, pout[7:0]}, 32'h7A);
    acc(12'h02C, 1'b1, 8'h00, 9'h000);
    repeat (3) @(posedge pclk);
    acc(12'h024, 1'b0, 8'h00, 9'h07A);
    acc(12'h02C, 1'b1, 8'hFF, 9'h000);
    acc(12'h024, 1'b0, 8'h00, 9'h000);
    pe <= 9'h000;
    ext <= 40'h0000800000;
    acc(12'h04C, 1'b1, 8'h00, 9'h000);
    acc(12'h06C, 1'b1, 8'h00, 9'h000);
    repeat (3) @(posedge pclk);
    chk({31'h0, rx_in}, 32'h1);
    acc(12'h000, 1'b1, 8'h02, 9'h000);
    repeat (3) @(posedge pclk);
    chk({31'h0, rx_in}, 32'h0);
    acc(12'h000, 1'b1, 8'h00, 9'h000);
    acc(12'h06C, 1'b1, 8'hFF, 9'h000);
    repeat (3) @(posedge pclk);
    chk({31'h0, rx_in}, 32'h0);
    // Steered inputs: ones only on the selected pins, then on the alternate pins after reselecting all inputs but capture/compare channel 3
    acc(12'h06C, 1'b1, 8'h00, 9'h000);
    ext <= 40'h00_000C_6800;
    acc(12'h000, 1'b1, 8'h09, 9'h000);
    chk({24'h0, sel1_o}, 32'h09);
    chk({31'h0, sel2_o}, 32'h1);
    repeat (3) @(posedge pclk);
    chk({27'h0, fin}, 32'h1F);
    chk({31'h0, rx_in}, 32'h0);
    ext <= 40'h00_0012_8100;
    acc(12'h000, 1'b1, 8'h52, 9'h000);
    repeat (3) @(posedge pclk);
    chk({27'h0, fin}, 32'h1B);
    chk({31'h0, rx_in}, 32'h1);
    // Pull-ups on idle inputs, dropped where a peripheral owns the pin
    acc(12'h070, 1'b1, 8'hFF, 9'h000);
    chk({24'h0, ppu[23:16]}, 32'hFF);
    pe <= 9'h010;
    @(posedge pclk);
    chk({24'h0, ppu[23:16]}, 32'hDF);
    report_and_stop;
  end
endmodule // alternate_pin_function_steering_tb_top
